// file: rtl/wbp_top.sv
// Purpose: Watchdog counter and square-wave beeper sharing one control register.
// Assumes: CPU core on the same clock drives the register port and mode inputs.
// Notes: Overflow interrupts are one-cycle pulses; the interrupt controller latches them.
`timescale 1ns/1ns
module wbp_top
  import wbp_pkg::*;
#(
  parameter logic NMI_SEL_VAL = 1'b1
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // Register port
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic [7:0] I_SFR_WDATA,
  output logic [7:0] O_SFR_RDATA,
  // Core status and interrupt controller
  input wire logic I_PDOWN,
  input wire logic I_WDT_INT_ENABLE,
  output logic O_WDT_NMI,
  output logic O_WDT_INT,
  output logic O_WDT_RUNNING,
  // Shared port pin
  input wire logic I_PORT_LATCH,
  input wire logic I_PORT_DIR_OUT,
  output logic O_BEEPER_PIN_O,
  output logic O_BEEPER_PIN_OE
);

  // ==========================================================================
  // Register file
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] cnt_val_ff, nxt_cnt_val;
  logic [7:0] rdata_ff, nxt_rdata;
  logic wr_ctrl, wr_cnt, restart;

  assign wr_ctrl = I_SFR_WR && (I_SFR_ADDR == WBP_CTRL_ADDR);
  assign wr_cnt = I_SFR_WR && (I_SFR_ADDR == WBP_CNT_ADDR);
  // A pending run/restart bit is acted on in the cycle after it is written
  assign restart = ctrl_ff[WBP_WDT_RR_BIT];

  logic [7:0] wdt_cnt_ff, nxt_wdt_cnt;
  wbp_wdt_state_t state_ff, nxt_state;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_cnt_val = cnt_val_ff;
    if (wr_ctrl) begin
      nxt_ctrl = I_SFR_WDATA;
    end else if (restart) begin
      nxt_ctrl[WBP_WDT_RR_BIT] = 1'b0;
    end
    if (wr_cnt) begin
      nxt_cnt_val = I_SFR_WDATA;
    end
    nxt_rdata = WBP_RD_NONE;
    if (I_SFR_ADDR == WBP_CTRL_ADDR) begin
      nxt_rdata = ctrl_ff;
    end else if (I_SFR_ADDR == WBP_CNT_ADDR) begin
      // Live count while running so software can watch it advance
      nxt_rdata = (state_ff == WBP_WDT_RUN) ? wdt_cnt_ff : cnt_val_ff;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_ff <= WBP_CTRL_RST;
      cnt_val_ff <= WBP_CNT_RST;
      rdata_ff <= WBP_RD_NONE;
    end else begin
      ctrl_ff <= nxt_ctrl;
      cnt_val_ff <= nxt_cnt_val;
      rdata_ff <= nxt_rdata;
    end
  end

  assign O_SFR_RDATA = rdata_ff;

  // ==========================================================================
  // Watchdog counter
  logic [WBP_PRE_W-1:0] pre_ff, nxt_pre;
  logic [12:0] tick_mask;
  logic tick, ovf;
  logic nmi_ff, nxt_nmi, int_ff, nxt_int;
  logic nmi_type;
  // Registered copy of the state so the status pin comes straight from a flop
  logic running_ff, nxt_running;

  assign tick_mask = wbp_tick_mask(ctrl_ff[WBP_WDT_CSEL_HI:WBP_WDT_CSEL_LO]);
  assign tick = ((pre_ff & tick_mask) == tick_mask);
  assign nmi_type = (ctrl_ff[WBP_WDT_TYPE_BIT] == NMI_SEL_VAL);
  assign ovf = (state_ff == WBP_WDT_RUN) && !restart && !I_PDOWN && tick
    && (wdt_cnt_ff == WBP_CNT_MAX);

  always_comb begin
    nxt_state = state_ff;
    nxt_wdt_cnt = wdt_cnt_ff;
    nxt_pre = pre_ff;
    unique case (state_ff)
      WBP_WDT_STOP: begin
        if (restart) begin
          nxt_state = WBP_WDT_RUN;
          nxt_wdt_cnt = cnt_val_ff;
          nxt_pre = '0;
        end
      end
      WBP_WDT_RUN: begin
        // No path back to stop: a write only restarts
        if (restart) begin
          nxt_wdt_cnt = cnt_val_ff;
          nxt_pre = '0;
        end else if (!I_PDOWN) begin
          nxt_pre = pre_ff + 1'b1;
          if (tick) begin
            // Wrap reloads the start value so the next period is the same length
            nxt_wdt_cnt = ovf ? cnt_val_ff : wdt_cnt_ff + 8'h01;
          end
        end
      end
    endcase
    nxt_nmi = ovf && nmi_type;
    nxt_int = ovf && !nmi_type && I_WDT_INT_ENABLE;
    nxt_running = (nxt_state == WBP_WDT_RUN);
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      state_ff <= WBP_WDT_STOP;
      wdt_cnt_ff <= WBP_CNT_RST;
      pre_ff <= '0;
      nmi_ff <= 1'b0;
      int_ff <= 1'b0;
      running_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wdt_cnt_ff <= nxt_wdt_cnt;
      pre_ff <= nxt_pre;
      nmi_ff <= nxt_nmi;
      int_ff <= nxt_int;
      running_ff <= nxt_running;
    end
  end

  assign O_WDT_NMI = nmi_ff;
  assign O_WDT_INT = int_ff;
  assign O_WDT_RUNNING = running_ff;

  // ==========================================================================
  // Beeper
  logic [WBP_BEEP_W-1:0] beep_div_ff, nxt_beep_div;
  logic [WBP_BEEP_W-1:0] beep_half;
  logic beep_wave_ff, nxt_beep_wave;
  logic pin_o_ff, nxt_pin_o, pin_oe_ff;
  logic beep_run;

  assign beep_run = ctrl_ff[WBP_BEEP_RUN_BIT];
  // Half period per toggle; all four divisors are even, so no duty skew
  assign beep_half = wbp_beep_div(ctrl_ff[WBP_BEEP_FSEL_HI:WBP_BEEP_FSEL_LO]) >> 1;

  always_comb begin
    nxt_beep_div = '0;
    nxt_beep_wave = 1'b0;
    if (beep_run) begin
      if (beep_div_ff >= beep_half - 1'b1) begin
        nxt_beep_wave = !beep_wave_ff;
      end else begin
        nxt_beep_div = beep_div_ff + 1'b1;
        nxt_beep_wave = beep_wave_ff;
      end
    end
    // Tone replaces the port latch only while the beeper runs
    nxt_pin_o = beep_run ? beep_wave_ff : I_PORT_LATCH;
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      beep_div_ff <= '0;
      beep_wave_ff <= 1'b0;
      pin_o_ff <= 1'b1;
      pin_oe_ff <= 1'b0;
    end else begin
      beep_div_ff <= nxt_beep_div;
      beep_wave_ff <= nxt_beep_wave;
      pin_o_ff <= nxt_pin_o;
      // Direction comes from the port mode register
      pin_oe_ff <= I_PORT_DIR_OUT;
    end
  end

  assign O_BEEPER_PIN_O = pin_o_ff;
  assign O_BEEPER_PIN_OE = pin_oe_ff;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  sequence s_restart_req;
    restart && !wr_ctrl;
  endsequence

  sequence s_counting;
    (state_ff == WBP_WDT_RUN) && !restart && !I_PDOWN;
  endsequence

  sequence s_wrap;
    s_counting ##0 (tick && wdt_cnt_ff == WBP_CNT_MAX);
  endsequence

  property p_start;
    (state_ff == WBP_WDT_STOP) && restart |=> (state_ff == WBP_WDT_RUN);
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_load;
    restart |=> (wdt_cnt_ff == $past(cnt_val_ff));
  endproperty
  a_load: assert property (p_load) else $error("counter not loaded");

  property p_ovf_nmi;
    s_counting ##0 (tick && wdt_cnt_ff == WBP_CNT_MAX && nmi_type) |=> O_WDT_NMI && !O_WDT_INT;
  endproperty
  a_ovf_nmi: assert property (p_ovf_nmi) else $error("no nmi on overflow");

  property p_type;
    O_WDT_INT |-> !$past(nmi_type) && !O_WDT_NMI;
  endproperty
  a_type: assert property (p_type) else $error("wrong interrupt type");

  property p_mask;
    s_counting ##0 (tick && wdt_cnt_ff == WBP_CNT_MAX && !nmi_type && !I_WDT_INT_ENABLE)
      |=> !O_WDT_INT && !O_WDT_NMI;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt leaked");

  property p_ovf_int;
    s_wrap ##0 (!nmi_type && I_WDT_INT_ENABLE) |=> O_WDT_INT && !O_WDT_NMI;
  endproperty
  a_ovf_int: assert property (p_ovf_int) else $error("maskable interrupt missed");

  property p_wrap_reload;
    s_wrap |=> wdt_cnt_ff == $past(cnt_val_ff);
  endproperty
  a_wrap_reload: assert property (p_wrap_reload) else $error("no reload on wrap");

  property p_rr_set;
    wr_ctrl && I_SFR_WDATA[WBP_WDT_RR_BIT] |=> ctrl_ff[WBP_WDT_RR_BIT];
  endproperty
  a_rr_set: assert property (p_rr_set) else $error("run/restart write lost");

  property p_autoclear;
    s_restart_req |=> !ctrl_ff[WBP_WDT_RR_BIT];
  endproperty
  a_autoclear: assert property (p_autoclear) else $error("restart bit stuck");

  property p_no_stop;
    (state_ff == WBP_WDT_RUN) |=> (state_ff == WBP_WDT_RUN) [*2];
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("watchdog stopped");

  property p_pdown;
    (state_ff == WBP_WDT_RUN) && !restart && I_PDOWN |=> $stable(wdt_cnt_ff) && $stable(pre_ff);
  endproperty
  a_pdown: assert property (p_pdown) else $error("count moved in power-down");

  property p_div1;
    s_counting ##0 (ctrl_ff[WBP_WDT_CSEL_HI:WBP_WDT_CSEL_LO] == 3'h0
      && wdt_cnt_ff != WBP_CNT_MAX) |=> wdt_cnt_ff == $past(wdt_cnt_ff) + 8'h01;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided tick missed");

  property p_beep_toggle;
    beep_run && (beep_div_ff == beep_half - 1'b1) |=> beep_wave_ff != $past(beep_wave_ff);
  endproperty
  a_beep_toggle: assert property (p_beep_toggle) else $error("tone toggle missed");

  property p_pin;
    beep_run |=> O_BEEPER_PIN_O == $past(beep_wave_ff);
  endproperty
  a_pin: assert property (p_pin) else $error("tone not on pin");

  property p_pin_idle;
    !beep_run |=> O_BEEPER_PIN_O == $past(I_PORT_LATCH);
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("pin not handed to latch");

  property p_beep_off;
    !beep_run |=> beep_div_ff == '0 && !beep_wave_ff;
  endproperty
  a_beep_off: assert property (p_beep_off) else $error("beeper not held");

endmodule

// file: rtl/wbp_pkg.sv
// Purpose: Shared constants and types of the watchdog and beeper block.
// Assumes: Byte-wide special function register access from the CPU core.
// Notes: Register addresses, field positions, reset values and dividers.
package wbp_pkg;
  // ==========================================================================
  // Register addresses, reset values, count limit and unmapped read value
  localparam logic [7:0] WBP_CTRL_ADDR = 8'hF8;
  localparam logic [7:0] WBP_CNT_ADDR = 8'hF9;
  localparam logic [7:0] WBP_CTRL_RST = 8'h00;
  localparam logic [7:0] WBP_CNT_RST = 8'h00;
  localparam logic [7:0] WBP_CNT_MAX = 8'hFF;
  localparam logic [7:0] WBP_RD_NONE = 8'h00;

  // ==========================================================================
  // Control register fields
  localparam int WBP_BEEP_RUN_BIT = 7;
  localparam int WBP_BEEP_FSEL_HI = 6;
  localparam int WBP_BEEP_FSEL_LO = 5;
  localparam int WBP_WDT_RR_BIT = 4;
  localparam int WBP_WDT_TYPE_BIT = 3;
  localparam int WBP_WDT_CSEL_HI = 2;
  localparam int WBP_WDT_CSEL_LO = 0;

  // ==========================================================================
  // Dividers
  localparam int WBP_PRE_W = 13;
  localparam int WBP_BEEP_W = 13;
  localparam logic [12:0] WBP_BEEP_DIV0 = 13'h1770;
  localparam logic [12:0] WBP_BEEP_DIV1 = 13'h0BB8;
  localparam logic [12:0] WBP_BEEP_DIV2 = 13'h0640;
  localparam logic [12:0] WBP_BEEP_DIV3 = 13'h0384;

  typedef enum logic {WBP_WDT_STOP, WBP_WDT_RUN} wbp_wdt_state_t;

  // Prescaler mask: low bits that must all be ones for one counting tick
  function automatic logic [12:0] wbp_tick_mask(input logic [2:0] sel);
    logic [12:0] m;
    m = 13'h0000;
    case (sel)
      3'h0: m = 13'h0000;
      3'h1: m = 13'h0007;
      3'h2: m = 13'h000F;
      3'h3: m = 13'h001F;
      3'h4: m = 13'h007F;
      3'h5: m = 13'h01FF;
      3'h6: m = 13'h07FF;
      default: m = 13'h1FFF;
    endcase
    return m;
  endfunction

  function automatic logic [12:0] wbp_beep_div(input logic [1:0] sel);
    logic [12:0] d;
    d = WBP_BEEP_DIV0;
    case (sel)
      2'h0: d = WBP_BEEP_DIV0;
      2'h1: d = WBP_BEEP_DIV1;
      2'h2: d = WBP_BEEP_DIV2;
      default: d = WBP_BEEP_DIV3;
    endcase
    return d;
  endfunction
endpackage

// file: testbench/wbp_top_test.sv
// Purpose: Self-checking bench for the watchdog and beeper block.
// Assumes: Bench drives all inputs at the falling clock edge.
// Notes: The watchdog cannot be stopped, so every table row starts from reset.
`timescale 1ns/1ns
module wbp_top_test
  import wbp_pkg::*;
;
  // ==========================================================================
  // Signals and table
  typedef struct {logic [7:0] ctrl; logic ien; int exp; logic nmi; logic irq;} wbp_row_t;
  logic clk, rst, wr, pdown, ien, latch, dir;
  logic [7:0] addr, wdata, rdata, a, b;
  logic nmi, irq, running, pin_o, pin_oe;
  int fail_count, checks_done, n;
  // Watchdog rows load FE, so the first overflow needs two ticks
  wbp_row_t rows [14] = '{'{8'h18, 0, 3, 1, 0}, '{8'h19, 0, 17, 1, 0},
    '{8'h1A, 0, 33, 1, 0}, '{8'h1B, 0, 65, 1, 0}, '{8'h1C, 0, 257, 1, 0},
    '{8'h1D, 0, 1025, 1, 0}, '{8'h1E, 0, 4097, 1, 0}, '{8'h1F, 1, 16385, 1, 0},
    '{8'h12, 1, 33, 0, 1}, '{8'h12, 0, 0, 0, 0}, '{8'h80, 0, 3000, 0, 0},
    '{8'hA0, 0, 1500, 0, 0}, '{8'hC0, 0, 800, 0, 0}, '{8'hE0, 0, 450, 0, 0}};

  wbp_top #(.NMI_SEL_VAL(1'b1)) u_wbp_top (.I_MCLK(clk), .I_RST(rst), .I_SFR_ADDR(addr),
    .I_SFR_WR(wr), .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata), .I_PDOWN(pdown),
    .I_WDT_INT_ENABLE(ien), .O_WDT_NMI(nmi), .O_WDT_INT(irq), .O_WDT_RUNNING(running),
    .I_PORT_LATCH(latch), .I_PORT_DIR_OUT(dir), .O_BEEPER_PIN_O(pin_o),
    .O_BEEPER_PIN_OE(pin_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
  endtask

  // Extra idle cycle keeps back-to-back calls from touching wr twice in one step
  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
    addr = ad;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] ad, output logic [7:0] d);
    addr = ad;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic wait_pin(input int bound, output int cnt);
    logic p;
    p = pin_o;
    cnt = 0;
    while (pin_o === p) begin
      @(negedge clk);
      cnt++;
      if (cnt > bound) begin
        fail_count++;
        stop_test();
      end
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {rst, wr, pdown, ien, latch} = 5'h11;
    dir = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    fail_count = 0;
    checks_done = 0;
    @(negedge clk);
    foreach (rows[i]) begin
      do_reset();
      ien = rows[i].ien;
      if (rows[i].ctrl[7]) begin
        wr_reg(WBP_CTRL_ADDR, rows[i].ctrl);
        wait_pin(7000, n);
        wait_pin(7000, n);
        chk(16'(n), 16'(rows[i].exp));
      end else begin
        wr_reg(WBP_CNT_ADDR, 8'hFE);
        wr_reg(WBP_CTRL_ADDR, rows[i].ctrl);
        n = 1;
        while (n < rows[i].exp + 40 && nmi !== 1'b1 && irq !== 1'b1) begin
          @(negedge clk);
          n++;
        end
        if (rows[i].exp != 0 && n >= rows[i].exp + 40) begin
          fail_count++;
          stop_test();
        end
        if (rows[i].exp != 0) begin
          chk(16'(n), 16'(rows[i].exp));
        end
        chk({14'h0, nmi, irq}, {14'h0, rows[i].nmi, rows[i].irq});
        @(negedge clk);
        chk({14'h0, nmi, irq}, 16'h0000);
      end
    end
    // Reset values, unmapped place, ignored unmapped write
    do_reset();
    rd_reg(WBP_CTRL_ADDR, a);
    chk({8'h00, a}, {8'h00, WBP_CTRL_RST});
    rd_reg(WBP_CNT_ADDR, a);
    chk({8'h00, a}, {8'h00, WBP_CNT_RST});
    wr_reg(8'hF7, 8'hFF);
    rd_reg(8'hF0, a);
    chk({8'h00, a}, {8'h00, WBP_RD_NONE});
    wr_reg(WBP_CNT_ADDR, 8'h5A);
    rd_reg(WBP_CNT_ADDR, a);
    chk({8'h00, a}, 16'h005A);
    rd_reg(WBP_CTRL_ADDR, a);
    chk({8'h00, a, 6'h00, running, pin_oe}, 16'h0001);
    wr_reg(WBP_CTRL_ADDR, 8'h6B);
    rd_reg(WBP_CTRL_ADDR, a);
    chk({8'h00, a}, 16'h006B);
    // Auto-clear, no stop, restart reload
    wr_reg(WBP_CNT_ADDR, 8'h80);
    wr_reg(WBP_CTRL_ADDR, 8'h10);
    repeat (40) @(negedge clk);
    rd_reg(WBP_CTRL_ADDR, a);
    chk({8'h00, a}, 16'h0000);
    wr_reg(WBP_CTRL_ADDR, 8'h00);
    chk({15'h0, running}, 16'h0001);
    wr_reg(WBP_CTRL_ADDR, 8'h10);
    rd_reg(WBP_CNT_ADDR, a);
    chk({15'h0, (a >= 8'h80 && a <= 8'h86)}, 16'h0001);
    // Power-down freezes the counter, normal run resumes it
    pdown = 1'b1;
    rd_reg(WBP_CNT_ADDR, a);
    repeat (20) @(negedge clk);
    rd_reg(WBP_CNT_ADDR, b);
    chk({8'h00, b}, {8'h00, a});
    pdown = 1'b0;
    repeat (5) @(negedge clk);
    rd_reg(WBP_CNT_ADDR, b);
    chk({15'h0, (b !== a)}, 16'h0001);
    // Beeper stop mid-period clears the divider and hands the pin back
    do_reset();
    wr_reg(WBP_CTRL_ADDR, 8'hE0);
    repeat (200) @(negedge clk);
    wr_reg(WBP_CTRL_ADDR, 8'h00);
    latch = 1'b1;
    repeat (2) @(negedge clk);
    chk({15'h0, pin_o}, 16'h0001);
    latch = 1'b0;
    repeat (2) @(negedge clk);
    chk({15'h0, pin_o}, 16'h0000);
    wr_reg(WBP_CTRL_ADDR, 8'hE0);
    wait_pin(7000, n);
    chk({15'h0, (n >= 445 && n <= 455)}, 16'h0001);
    dir = 1'b0;
    repeat (2) @(negedge clk);
    chk({15'h0, pin_oe}, 16'h0000);
    stop_test();
  end
endmodule
